/* File: hw/gpac_ports.sv */
// Strobed register access was left to the implementer.
`include "gpac_cfg.svh"

module gpac_ports #(
    parameter bit HAS_PORT_C = 1'b1 // the variant with the third port
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic POR_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [`GPAC_A_W-1:0] FIRST_PORT_PINS_IN,
    output logic [`GPAC_A_W-1:0] FIRST_PORT_PINS_OUT,
    output logic [`GPAC_A_W-1:0] FIRST_PORT_PINS_OE,
    input wire logic [`GPAC_C_W-1:0] THIRD_PORT_PIN_BITS_IN,
    output logic [`GPAC_C_W-1:0] THIRD_PORT_PIN_BITS_OUT,
    output logic [`GPAC_C_W-1:0] THIRD_PORT_PIN_BITS_OE,
    output logic TIMER_EXTERNAL_CLOCK_IN
);
    // index of the open-drain bit that doubles as the timer clock pin
    localparam int OD = `GPAC_A_OD_BIT;

    // any reset: external reset or power-on reset
    logic rst_all_n;
    assign rst_all_n = RSTN & POR_N;

    // conditioned pin levels
    logic [`GPAC_A_W-1:0] a_pins;
    logic [`GPAC_C_W-1:0] c_pins;

    // port registers
    logic [`GPAC_A_W-1:0] first_port_direction; // 1 = input
    logic [`GPAC_A_W-1:0] a_latch; // port A output latch
    logic [`GPAC_C_W-1:0] third_port_direction; // 1 = input
    logic [`GPAC_C_W-1:0] c_latch; // port C output latch

    // next values
    logic [`GPAC_A_W-1:0] next_a_dir;
    logic [`GPAC_A_W-1:0] next_a_latch;
    logic [`GPAC_C_W-1:0] next_c_dir;
    logic [`GPAC_C_W-1:0] next_c_latch;
    logic [7:0] next_rdata;
    logic [`GPAC_A_W-1:0] next_a_out;
    logic [`GPAC_A_W-1:0] next_a_oe;
    logic [`GPAC_C_W-1:0] next_c_out;
    logic [`GPAC_C_W-1:0] next_c_oe;
    logic next_tclk;
    gpac_pkg::gpac_sel_t sel; // decoded register

    // pin conditioners for both ports
    gpac_sync #(.W(`GPAC_A_W)) u_sync_a (
        .clk(CLK),
        .rstn(rst_all_n),
        .d(FIRST_PORT_PINS_IN),
        .q(a_pins)
    );
    // third port through the same conditioner
    gpac_sync #(.W(`GPAC_C_W)) u_sync_c (
        .clk(CLK),
        .rstn(rst_all_n),
        .d(THIRD_PORT_PIN_BITS_IN),
        .q(c_pins)
    );

    // address decode
    always_comb begin
        // only the four port registers decode, everything else selects none
        case (ADDR)
            `GPAC_ADDR_A_PINS: sel = gpac_pkg::GPAC_SEL_A_PINS;
            `GPAC_ADDR_A_DIR: sel = gpac_pkg::GPAC_SEL_A_DIR;
            // the third port decodes only on its variant
            `GPAC_ADDR_C_PINS: begin
                sel = HAS_PORT_C ? gpac_pkg::GPAC_SEL_C_PINS : gpac_pkg::GPAC_SEL_NONE;
            end
            `GPAC_ADDR_C_DIR: begin
                sel = HAS_PORT_C ? gpac_pkg::GPAC_SEL_C_DIR : gpac_pkg::GPAC_SEL_NONE;
            end
            default: sel = gpac_pkg::GPAC_SEL_NONE;
        endcase
    end

    // register writes, read data and pin drive
    always_comb begin
        // default: hold every register, read bus at zero
        next_a_dir = first_port_direction;
        next_a_latch = a_latch;
        next_c_dir = third_port_direction;
        next_c_latch = c_latch;
        next_rdata = 8'h00;
        // writes: the whole latch takes the modified byte
        if (WR) begin
            case (sel)
                gpac_pkg::GPAC_SEL_A_PINS: next_a_latch = WDATA[`GPAC_A_W-1:0];
                gpac_pkg::GPAC_SEL_A_DIR: next_a_dir = WDATA[`GPAC_A_W-1:0];
                gpac_pkg::GPAC_SEL_C_PINS: next_c_latch = WDATA;
                gpac_pkg::GPAC_SEL_C_DIR: next_c_dir = WDATA;
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // reads return pin levels or direction, port A upper bits zero
        if (RD) begin
            case (sel)
                gpac_pkg::GPAC_SEL_A_PINS: next_rdata = {3'h0, a_pins};
                gpac_pkg::GPAC_SEL_A_DIR: next_rdata = {3'h0, first_port_direction};
                gpac_pkg::GPAC_SEL_C_PINS: next_rdata = c_pins;
                gpac_pkg::GPAC_SEL_C_DIR: next_rdata = third_port_direction;
                default: next_rdata = 8'h00;
            endcase
        end
        // push-pull bits drive the latch when direction is zero
        next_a_out = next_a_latch;
        next_a_oe = ~next_a_dir;
        // open-drain bit: only ever pulls low
        next_a_out[OD] = 1'b0;
        next_a_oe[OD] = ~next_a_dir[OD] & ~next_a_latch[OD];
        // the third port drives only on its variant
        next_c_out = HAS_PORT_C ? next_c_latch : 8'h00;
        next_c_oe = HAS_PORT_C ? ~next_c_dir : 8'h00;
        // timer samples the same conditioned pin level
        next_tclk = a_pins[OD];
    end

    // direction registers and pin drive: any reset makes all inputs
    always_ff @(posedge CLK or negedge rst_all_n) begin
        if (!rst_all_n) begin
            // outputs released and read bus quiet while reset is held
            first_port_direction <= `GPAC_A_DIR_RST;
            third_port_direction <= `GPAC_C_DIR_RST;
            RDATA <= 8'h00;
            FIRST_PORT_PINS_OUT <= '0;
            FIRST_PORT_PINS_OE <= '0;
            THIRD_PORT_PIN_BITS_OUT <= '0;
            THIRD_PORT_PIN_BITS_OE <= '0;
            TIMER_EXTERNAL_CLOCK_IN <= 1'b0;
        end else begin
            // every output follows its next value
            first_port_direction <= next_a_dir;
            third_port_direction <= next_c_dir;
            RDATA <= next_rdata;
            FIRST_PORT_PINS_OUT <= next_a_out;
            FIRST_PORT_PINS_OE <= next_a_oe;
            THIRD_PORT_PIN_BITS_OUT <= next_c_out;
            THIRD_PORT_PIN_BITS_OE <= next_c_oe;
            TIMER_EXTERNAL_CLOCK_IN <= next_tclk;
        end
    end

    // data latches: cleared by power-on only, kept across other resets
    always_ff @(posedge CLK or negedge POR_N) begin
        if (!POR_N) begin
            // power-on gives a known value in place of an undefined one
            a_latch <= `GPAC_A_LATCH_POR;
            c_latch <= `GPAC_C_LATCH_POR;
        end else begin
            // other resets leave both latches alone
            a_latch <= next_a_latch;
            c_latch <= next_c_latch;
        end
    end

    // checks: they watch what this block drives
    // they run on the block clock and pause while any reset is held, except a_c_keep, which pauses on power-on reset only
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!rst_all_n);

    // a port A data write reaches the latch
    property p_a_write;
        (WR && ADDR == `GPAC_ADDR_A_PINS) |=> (a_latch == $past(WDATA[`GPAC_A_W-1:0]));
    endproperty
    a_a_write: assert property (p_a_write) else $error("port A latch missed write");

    // open-drain bit never drives high
    property p_od_low;
        FIRST_PORT_PINS_OE[OD] |-> !FIRST_PORT_PINS_OUT[OD];
    endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain bit drove high");

    // timer clock follows the pin level a cycle later
    property p_tclk;
        ##1 (TIMER_EXTERNAL_CLOCK_IN == $past(a_pins[OD]));
    endproperty
    a_tclk: assert property (p_tclk) else $error("timer clock not from pin");

    // push-pull bit 0 drives the latch value when output
    property p_pp_drive;
        (first_port_direction[0] == 1'b0) |-> FIRST_PORT_PINS_OE[0]
            && FIRST_PORT_PINS_OUT[0] == a_latch[0];
    endproperty
    a_pp_drive: assert property (p_pp_drive) else $error("push-pull bit not driven");

    // direction one releases every port C pin
    property p_c_float;
        (third_port_direction == `GPAC_C_DIR_RST)
            |-> (THIRD_PORT_PIN_BITS_OE == 8'h00);
    endproperty
    a_c_float: assert property (p_c_float) else $error("input pin still driven");

    // reads return pin levels, not the latch, with zero above
    property p_a_read;
        (RD && ADDR == `GPAC_ADDR_A_PINS) |=> (RDATA == {3'h0, $past(a_pins)});
    endproperty
    a_a_read: assert property (p_a_read) else $error("port A read not pins");

    // read data stand one cycle only
    property p_rd_gap;
        !RD |=> (RDATA == 8'h00);
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read data outside read slot");

    // port C write replaces the whole latch
    property p_c_write;
        (WR && ADDR == `GPAC_ADDR_C_PINS && HAS_PORT_C) |=> (c_latch == $past(WDATA));
    endproperty
    a_c_write: assert property (p_c_write) else $error("port C latch missed write");

    // after release of reset, both ports are inputs
    property p_dir_rst;
        $rose(rst_all_n) |-> (first_port_direction == `GPAC_A_DIR_RST)
            && (third_port_direction == `GPAC_C_DIR_RST);
    endproperty
    a_dir_rst: assert property (@(posedge CLK) p_dir_rst)
        else $error("direction not all inputs after reset");

    // port C direction read back
    property p_c_dir_read;
        (RD && ADDR == `GPAC_ADDR_C_DIR && HAS_PORT_C) |=> (RDATA == $past(third_port_direction));
    endproperty
    a_c_dir_read: assert property (p_c_dir_read) else $error("port C direction read wrong");

    // without the third port, its pins stay released
    property p_no_c;
        !HAS_PORT_C |-> (THIRD_PORT_PIN_BITS_OE == 8'h00);
    endproperty
    a_no_c: assert property (p_no_c) else $error("absent port drives pins");

    // latch survives a non-power-on reset
    property p_c_keep;
        (!RSTN && POR_N && !WR) |=> (c_latch == $past(c_latch));
    endproperty
    a_c_keep: assert property (@(posedge CLK) disable iff (!POR_N) p_c_keep)
        else $error("port C latch lost on reset");

    // direction register of port A keeps upper bits zero on read
    property p_a_dir_read;
        (RD && ADDR == `GPAC_ADDR_A_DIR) |=> (RDATA[7:5] == 3'h0);
    endproperty
    a_a_dir_read: assert property (p_a_dir_read) else $error("upper bits not zero");

    // a port A direction write keeps the five low bits
    property p_a_dir_write;
        (WR && ADDR == `GPAC_ADDR_A_DIR)
            |=> (first_port_direction == $past(WDATA[`GPAC_A_W-1:0]));
    endproperty
    a_a_dir_write: assert property (p_a_dir_write) else $error("A dir write lost");

    // a port C direction write lands whole on the present variant
    property p_c_dir_write;
        (WR && ADDR == `GPAC_ADDR_C_DIR && HAS_PORT_C)
            |=> (third_port_direction == $past(WDATA));
    endproperty
    a_c_dir_write: assert property (p_c_dir_write) else $error("C dir write lost");

    // present third port drives exactly its output bits from the latch
    property p_c_drive;
        HAS_PORT_C |-> (THIRD_PORT_PIN_BITS_OE == ~third_port_direction)
            && ((THIRD_PORT_PIN_BITS_OUT & THIRD_PORT_PIN_BITS_OE)
            == (c_latch & ~third_port_direction));
    endproperty
    a_c_drive: assert property (p_c_drive) else $error("port C drive not latch");

    // unmapped addresses read back zero
    property p_refused;
        (RD && sel == gpac_pkg::GPAC_SEL_NONE) |=> (RDATA == 8'h00);
    endproperty
    a_refused: assert property (p_refused) else $error("unmapped read not zero");

    // open-drain bit lets go unless set to output with a low latch
    property p_od_release;
        (first_port_direction[OD] || a_latch[OD]) |-> !FIRST_PORT_PINS_OE[OD];
    endproperty
    a_od_release: assert property (p_od_release) else $error("drain not released");

    // scenarios
    c_a_out: cover property (WR && ADDR == `GPAC_ADDR_A_DIR ##1 FIRST_PORT_PINS_OE != '0);
    c_od_pull: cover property (FIRST_PORT_PINS_OE[OD]);
    c_c_read: cover property (RD && ADDR == `GPAC_ADDR_C_PINS ##1 RDATA != 8'h00);
    c_tclk: cover property ($rose(TIMER_EXTERNAL_CLOCK_IN));
    c_c_drive: cover property (THIRD_PORT_PIN_BITS_OE != 8'h00);
endmodule

/* File: hw/gpac_cfg.svh */
`ifndef GPAC_CFG_SVH
`define GPAC_CFG_SVH

// file addresses of the port registers
`define GPAC_ADDR_A_PINS 8'h05
`define GPAC_ADDR_A_DIR 8'h85
`define GPAC_ADDR_C_PINS 8'h07
`define GPAC_ADDR_C_DIR 8'h87

// port widths
`define GPAC_A_W 5
`define GPAC_C_W 8

// position of the open-drain bit that also feeds the timer clock
`define GPAC_A_OD_BIT 4

// reset values of the direction registers (all inputs)
`define GPAC_A_DIR_RST 5'h1F
`define GPAC_C_DIR_RST 8'hFF

// value taken by the data latches at power-on (contents undefined)
`define GPAC_A_LATCH_POR 5'h00
`define GPAC_C_LATCH_POR 8'h00

`endif

/* File: hw/gpac_pkg.sv */
package gpac_pkg;
    // which register an access selects
    typedef enum logic [2:0] {
        GPAC_SEL_NONE,
        GPAC_SEL_A_PINS,
        GPAC_SEL_A_DIR,
        GPAC_SEL_C_PINS,
        GPAC_SEL_C_DIR
    } gpac_sel_t;
endpackage

/* File: hw/gpac_sync.sv */
// pin input conditioner: four flip-flops per bit, the output
// follows only once the second and third stages agree
module gpac_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1; // metastability catcher, read by s2 only
            logic s2; // second stage
            logic s3; // third stage
            logic next_q; // filtered level
            // filtered level moves only when stages two and three agree
            always_comb begin
                next_q = q[i];
                if (s2 == s3) begin
                    next_q = s3;
                end
            end
            // register the chain
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1 <= d[i];
                    s2 <= s1;
                    s3 <= s2;
                    q[i] <= next_q;
                end
            end
        end
    endgenerate
endmodule

/* File: tb/gpac_board.sv */
// board model: resolves each pin from the port drivers and the outside world
module gpac_board (
    input wire logic clk,
    input wire logic [4:0] a_out,
    input wire logic [4:0] a_oe,
    input wire logic [4:0] a_ext,
    input wire logic [4:0] a_ext_en,
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] c_ext,
    input wire logic [7:0] c_ext_en,
    output logic [4:0] a_pin,
    output logic [7:0] c_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip; // undriven lines other than open-drain bit 4 toggle so no stale level is read back
    initial flip = 1'b0;
    always @(posedge clk) flip <= ~flip;
    // port driver wins, then the outside driver, else a floating line
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            c_pin[i] = c_oe[i] ? c_out[i] : (c_ext_en[i] ? c_ext[i] : flip);
        end
        for (int i = 0; i < 5; i++) begin
            a_pin[i] = a_oe[i] ? a_out[i] : (a_ext_en[i] ? a_ext[i] : flip);
        end
        // open-drain line has a pull-up: released reads high
        a_pin[4] = a_oe[4] ? 1'b0 : (a_ext_en[4] ? a_ext[4] : 1'b1);
    end
endmodule

/* File: tb/tb_top.sv */
// bench for the port block, full variant beside the variant without port C
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, por_n, wr, rd, tmr;
    logic [7:0] addr, wdata, rdata, rdata_b, rv, rvb;
    logic [7:0] c_out, c_oe, c_pin, c_ext, c_ext_en, cb_oe;
    logic [4:0] a_out, a_oe, a_pin, a_ext, a_ext_en;
    int mismatches, checked, cycles;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    gpac_ports #(.HAS_PORT_C(1'b1)) i_dut (.CLK(clk), .RSTN(rstn), .POR_N(por_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .FIRST_PORT_PINS_IN(a_pin), .FIRST_PORT_PINS_OUT(a_out), .FIRST_PORT_PINS_OE(a_oe),
        .THIRD_PORT_PIN_BITS_IN(c_pin), .THIRD_PORT_PIN_BITS_OUT(c_out),
        .THIRD_PORT_PIN_BITS_OE(c_oe), .TIMER_EXTERNAL_CLOCK_IN(tmr));
    // variant without the third port shares bus and pins
    gpac_ports #(.HAS_PORT_C(1'b0)) i_dut_b (.CLK(clk), .RSTN(rstn), .POR_N(por_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata_b),
        .FIRST_PORT_PINS_IN(a_pin), .FIRST_PORT_PINS_OUT(), .FIRST_PORT_PINS_OE(),
        .THIRD_PORT_PIN_BITS_IN(c_pin), .THIRD_PORT_PIN_BITS_OUT(),
        .THIRD_PORT_PIN_BITS_OE(cb_oe), .TIMER_EXTERNAL_CLOCK_IN());
    gpac_board i_board (.clk(clk), .a_out(a_out), .a_oe(a_oe), .a_ext(a_ext),
        .a_ext_en(a_ext_en), .c_out(c_out), .c_oe(c_oe), .c_ext(c_ext),
        .c_ext_en(c_ext_en), .a_pin(a_pin), .c_pin(c_pin));
    // closing report
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
        rvb = rdata_b;
    endtask
    task automatic t_reset();
        check({3'h0, a_oe}, 8'h00, "port A floats");
        check(c_oe, 8'h00, "port C floats");
        rd_reg(8'h85);
        check(rv, 8'h1F, "A dir reset");
        rd_reg(8'h87);
        check(rv, 8'hFF, "C dir reset");
    endtask
    task automatic t_port_a();
        wr_reg(8'h85, 8'h00);
        wr_reg(8'h05, 8'hEF);
        check({3'h0, a_oe}, 8'h1F, "A drive, bit4 pulls low");
        check({3'h0, a_out}, 8'h0F, "A out, bit4 never high");
        wait_cyc(8);
        rd_reg(8'h05);
        check(rv, 8'h0F, "A pins");
        check({7'h0, tmr}, 8'h00, "timer sees low");
        wr_reg(8'h05, 8'h10);
        check({3'h0, a_oe}, 8'h0F, "bit4 released");
        check({3'h0, a_out}, 8'h00, "whole latch replaced");
        wait_cyc(8);
        rd_reg(8'h05);
        check(rv, 8'h10, "pull-up read");
        check({7'h0, tmr}, 8'h01, "timer sees high");
        wr_reg(8'h85, 8'hFF);
        rd_reg(8'h85);
        check(rv, 8'h1F, "upper dir bits");
        a_ext <= 5'h15;
        a_ext_en <= 5'h1F;
        wait_cyc(8);
        rd_reg(8'h05);
        check(rv, 8'h15, "pins not latch");
        a_ext_en <= 5'h00;
    endtask
    task automatic t_port_c();
        wr_reg(8'h87, 8'hF0);
        wr_reg(8'h07, 8'hA5);
        check(c_oe, 8'h0F, "C dir per bit");
        check(c_out & c_oe, 8'h05, "C drive");
        c_ext <= 8'h3C;
        c_ext_en <= 8'hF0;
        wait_cyc(8);
        rd_reg(8'h07);
        check(rv, 8'h35, "C pins");
        check(rvb, 8'h00, "no port C in small variant");
        check(cb_oe, 8'h00, "small variant never drives");
        rd_reg(8'h06);
        check(rv, 8'h00, "unmapped reads zero");
    endtask
    task automatic t_resets();
        @(posedge clk);
        rstn <= 1'b0;
        wait_cyc(2);
        check(c_oe, 8'h00, "C floats in reset");
        @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'h87);
        check(rv, 8'hFF, "C dir after reset");
        rd_reg(8'h85);
        check(rv, 8'h1F, "A dir after reset");
        wr_reg(8'h87, 8'h00);
        check(c_out, 8'hA5, "latch kept");
        @(posedge clk);
        por_n <= 1'b0;
        wait_cyc(2);
        @(posedge clk);
        por_n <= 1'b1;
        wr_reg(8'h87, 8'h00);
        check(c_out, 8'h00, "latch cleared at power-on");
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        rstn = 1'b0;
        por_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        a_ext = 5'h00;
        a_ext_en = 5'h00;
        c_ext = 8'h00;
        c_ext_en = 8'h00;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        wait_cyc(1);
        t_reset();
        t_port_a();
        t_port_c();
        t_resets();
        end_sim();
    end
endmodule
